// File: sadc_map.svh
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing.
// ----------------------------------------------------------------------------
`define SADC_CLK_MHZ 100
`define SADC_CONV_TIME_NS 20000
`define SADC_CONV_CYCLES ((`SADC_CONV_TIME_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_DCLK_QUARTER_NS 50
`define SADC_DCLK_QUARTER_CYCLES ((`SADC_DCLK_QUARTER_NS * `SADC_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// Data layout.
// ----------------------------------------------------------------------------
`define SADC_RESULT_BITS 16
`define SADC_SERIAL_BITS 16
`define SADC_MSB 15
`define SADC_BYTE_HI_TOP 15
`define SADC_BYTE_HI_BOT 8
`define SADC_BYTE_LO_TOP 7
`define SADC_BYTE_LO_BOT 0
`define SADC_FIFO_DEPTH 16
`define SADC_RESULT_RESET 16'h0000

`endif

// File: sadc_pkg.sv
package sadc_pkg;

   typedef struct packed {
      logic cs_n;
      logic rd_conv;
      logic byte_sel;
      logic output_code_select;
      logic serial_clock_source_select;
      logic tag_in;
      logic power_down_in;
      logic reference_disable;
      logic serial_bit_clock;
   } sadc_pins_t;

   typedef enum logic [1:0] {
      SADC_IDLE = 2'b00,
      SADC_CONV = 2'b01,
      SADC_PUSH = 2'b10,
      SADC_LOAD = 2'b11
   } sadc_state_t;

endpackage

// File: sadc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sadc_map.svh"

// ----------------------------------------------------------------------------
// Result FIFO.
// ----------------------------------------------------------------------------
module sadc_fifo #(
   parameter int WIDTH = `SADC_RESULT_BITS,
   parameter int DEPTH = `SADC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
      end else if (in_valid && !full) begin
         wr_q <= wr_q + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_q <= '0;
      end else if (out_ready && !empty) begin
         rd_q <= rd_q + (AW+1)'(1);
      end
   end
endmodule

// ----------------------------------------------------------------------------
// Converter control and data port.
// ----------------------------------------------------------------------------
module sadc_top import sadc_pkg::*; #(
   parameter int CONV_CYCLES = `SADC_CONV_CYCLES,
   parameter int QUARTER_CYCLES = `SADC_DCLK_QUARTER_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic rd_conv,
   input wire logic byte_sel,
   input wire logic output_code_select,
   input wire logic serial_clock_source_select,
   input wire logic tag_in,
   input wire logic power_down_in,
   input wire logic reference_disable,
   input wire logic [15:0] sample_in,
   input wire logic serial_bit_clock_i,
   output logic serial_bit_clock_o,
   output logic serial_bit_clock_oe,
   output logic serial_data_out,
   output logic [7:0] parallel_out,
   output logic parallel_oe,
   output logic busy,
   output logic power_save,
   output logic internal_ref_on
);
   sadc_pins_t pins_raw;
   sadc_pins_t meta_q;
   sadc_pins_t pin_q;
   logic start_n_q;
   logic ext_clk_q;
   sadc_state_t state_q;
   logic [31:0] conv_cnt_q;
   logic [15:0] sample_q;
   logic [15:0] result_q;
   logic fifo_in_ready;
   logic [15:0] fifo_out_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic start_n;
   logic start_evt;
   logic int_mode;
   logic [15:0] coded;
   logic [15:0] shift_q;
   logic [4:0] int_bits_q;
   logic [1:0] phase_q;
   logic [31:0] quarter_cnt_q;
   logic quarter_tick;
   logic int_active;
   logic int_clk_q;
   logic int_data_q;
   logic tag_hold_q;
   logic [4:0] ext_bits_q;
   logic ext_fall;
   logic read_phase;
   logic ser_q;
   logic [7:0] par_q;

   // -------------------------------------------------------------------------
   // Pin synchronisers.
   // -------------------------------------------------------------------------
   assign pins_raw = '{cs_n: cs_n, rd_conv: rd_conv, byte_sel: byte_sel,
      output_code_select: output_code_select,
      serial_clock_source_select: serial_clock_source_select, tag_in: tag_in,
      power_down_in: power_down_in, reference_disable: reference_disable,
      serial_bit_clock: serial_bit_clock_i};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '{cs_n: 1'b1, rd_conv: 1'b1, default: 1'b0};
         pin_q <= '{cs_n: 1'b1, rd_conv: 1'b1, default: 1'b0};
      end else begin
         meta_q <= pins_raw;
         pin_q <= meta_q;
      end
   end

   // -------------------------------------------------------------------------
   // Conversion start and busy.
   // -------------------------------------------------------------------------
   assign start_n = pin_q.cs_n | pin_q.rd_conv;
   assign start_evt = start_q_fall(start_n_q, start_n);
   assign int_mode = !pin_q.serial_clock_source_select;

   function automatic logic start_q_fall(input logic prev, input logic now);
      start_q_fall = prev && !now;
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_n_q <= 1'b1;
      end else begin
         start_n_q <= start_n;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= SADC_IDLE;
         conv_cnt_q <= '0;
         sample_q <= '0;
      end else begin
         unique case (state_q)
            SADC_IDLE: begin
               if (start_evt && !pin_q.power_down_in) begin
                  state_q <= SADC_CONV;
                  conv_cnt_q <= '0;
                  sample_q <= sample_in;
               end
            end
            SADC_CONV: begin
               if (conv_cnt_q == 32'(CONV_CYCLES - 1)) begin
                  state_q <= SADC_PUSH;
               end else begin
                  conv_cnt_q <= conv_cnt_q + 32'd1;
               end
            end
            SADC_PUSH: begin
               if (fifo_in_ready) begin
                  state_q <= SADC_LOAD;
               end
            end
            SADC_LOAD: begin
               if (fifo_out_valid && fifo_out_ready) begin
                  state_q <= SADC_IDLE;
               end
            end
         endcase
      end
   end

   assign busy = (state_q == SADC_IDLE);
   assign power_save = pin_q.power_down_in;
   assign internal_ref_on = !pin_q.reference_disable;

   // -------------------------------------------------------------------------
   // Result buffer and output register.
   // -------------------------------------------------------------------------
   assign fifo_out_ready = (state_q == SADC_LOAD) && !int_active;

   sadc_fifo #(
      .WIDTH(`SADC_RESULT_BITS),
      .DEPTH(`SADC_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(sample_q),
      .in_valid(state_q == SADC_PUSH),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result_q <= `SADC_RESULT_RESET;
      end else if (fifo_out_valid && fifo_out_ready) begin
         result_q <= fifo_out_data;
      end
   end

   // Two's complement is the straight-binary code with the MSB inverted.
   assign coded = {result_q[`SADC_MSB] ^ !pin_q.output_code_select, result_q[14:0]};

   // -------------------------------------------------------------------------
   // Parallel port.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         par_q <= '0;
      end else if (pin_q.byte_sel) begin
         par_q <= coded[`SADC_BYTE_LO_TOP:`SADC_BYTE_LO_BOT];
      end else begin
         par_q <= coded[`SADC_BYTE_HI_TOP:`SADC_BYTE_HI_BOT];
      end
   end

   assign parallel_out = par_q;
   assign parallel_oe = !pin_q.cs_n && pin_q.rd_conv;

   // -------------------------------------------------------------------------
   // Internal bit clock burst.
   // -------------------------------------------------------------------------
   assign int_active = (int_bits_q != 5'd0);
   assign quarter_tick = int_active && (quarter_cnt_q == 32'(QUARTER_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (!rst_n || !int_active) begin
         quarter_cnt_q <= '0;
      end else if (quarter_tick) begin
         quarter_cnt_q <= '0;
      end else begin
         quarter_cnt_q <= quarter_cnt_q + 32'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         int_bits_q <= '0;
         phase_q <= '0;
         shift_q <= '0;
         int_clk_q <= 1'b0;
         int_data_q <= 1'b0;
         tag_hold_q <= 1'b0;
      end else if (start_evt && busy && !pin_q.power_down_in && int_mode) begin
         int_bits_q <= 5'(`SADC_SERIAL_BITS);
         phase_q <= '0;
         shift_q <= {coded[14:0], 1'b0};
         int_data_q <= coded[`SADC_MSB];
         int_clk_q <= 1'b0;
         tag_hold_q <= pin_q.tag_in;
      end else if (quarter_tick) begin
         phase_q <= phase_q + 2'd1;
         unique case (phase_q)
            2'd0: int_clk_q <= 1'b1;
            2'd1: int_clk_q <= 1'b1;
            2'd2: int_clk_q <= 1'b0;
            2'd3: begin
               // Data moves a quarter period after the falling edge.
               int_bits_q <= int_bits_q - 5'd1;
               int_data_q <= shift_q[`SADC_MSB];
               shift_q <= {shift_q[14:0], 1'b0};
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // External bit clock shifting.
   // -------------------------------------------------------------------------
   assign read_phase = !pin_q.cs_n && pin_q.rd_conv;
   assign ext_fall = ext_clk_q && !pin_q.serial_bit_clock;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext_clk_q <= 1'b0;
      end else begin
         ext_clk_q <= pin_q.serial_bit_clock;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !read_phase || int_mode) begin
         ext_bits_q <= '0;
      end else if (ext_fall && ext_bits_q != 5'(`SADC_SERIAL_BITS)) begin
         ext_bits_q <= ext_bits_q + 5'd1;
      end
   end

   // -------------------------------------------------------------------------
   // Serial output mux.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ser_q <= 1'b0;
      end else if (int_mode) begin
         ser_q <= int_active ? int_data_q : tag_hold_q;
      end else if (ext_bits_q == 5'(`SADC_SERIAL_BITS)) begin
         ser_q <= read_phase ? pin_q.tag_in : 1'b0;
      end else begin
         ser_q <= coded[4'(`SADC_MSB - ext_bits_q)];
      end
   end

   assign serial_data_out = ser_q;
   assign serial_bit_clock_o = int_clk_q;
   assign serial_bit_clock_oe = int_mode;
endmodule
`default_nettype wire

// File: sadc_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ------------
// Port checks.
// ------------
module sadc_chk #(
   parameter int CONV_CYCLES = 20,
   parameter int QUARTER_CYCLES = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic rd_conv,
   input wire logic serial_clock_source_select,
   input wire logic power_down_in,
   input wire logic reference_disable,
   input wire logic serial_bit_clock_o,
   input wire logic serial_bit_clock_oe,
   input wire logic serial_data_out,
   input wire logic parallel_oe,
   input wire logic busy,
   input wire logic power_save,
   input wire logic internal_ref_on
);
   localparam int BMAX = 600;
   wire logic go_lvl;
   wire logic rd_lvl;
   assign go_lvl = !(cs_n | rd_conv);
   assign rd_lvl = !cs_n && rd_conv;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_oe_on: assert property (rd_lvl [*4] |-> parallel_oe)
      else $error("bus not driven");
   a_oe_off: assert property ((!rd_lvl) [*4] |-> !parallel_oe)
      else $error("bus driven");
   a_start_cause: assert property ($fell(busy) |-> $past(go_lvl, 3) && !$past(power_down_in, 3))
      else $error("start without cause");
   a_busy_len: assert property ($fell(busy) |-> !busy [*8] ##[1:BMAX] busy)
      else $error("busy length");
   a_pd_block: assert property (power_down_in [*8] ##0 busy |=> busy)
      else $error("start in power down");
   a_pd_flag: assert property ($stable(power_down_in) [*4] |-> power_save == power_down_in)
      else $error("power save flag");
   a_ref_flag: assert property ($stable(reference_disable) [*4] |-> internal_ref_on != reference_disable)
      else $error("reference flag");
   a_clk_dir: assert property ($stable(serial_clock_source_select) [*4]
      |-> serial_bit_clock_oe != serial_clock_source_select)
      else $error("bit clock direction");
   a_clk_idle: assert property (busy && serial_bit_clock_oe |-> !serial_bit_clock_o)
      else $error("bit clock not idle");
   a_bit_hold: assert property (serial_bit_clock_oe && $changed(serial_bit_clock_o)
      |-> $stable(serial_data_out))
      else $error("data moved at clock edge");
endmodule
bind sadc_top sadc_chk #(.CONV_CYCLES(CONV_CYCLES), .QUARTER_CYCLES(QUARTER_CYCLES)) u_chk (
   .clk, .rst_n, .cs_n, .rd_conv, .serial_clock_source_select, .power_down_in,
   .reference_disable, .serial_bit_clock_o, .serial_bit_clock_oe, .serial_data_out,
   .parallel_oe, .busy, .power_save, .internal_ref_on);
`default_nettype wire

// File: sadc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------
// Host bit clock.
// ----------------
module sadc_host_model (
   input wire logic clk,
   input wire logic go,
   input wire logic sdo,
   output logic sck,
   output logic [16:0] rx,
   output logic done
);
   logic [4:0] n_q;
   logic [3:0] ph_q;
   initial begin
      sck = 1'b0;
      rx = 17'h00000;
      n_q = 5'h00;
      ph_q = 4'h0;
   end
   assign done = (n_q == 5'h11);
   always @(posedge clk) begin
      if (!go) begin
         n_q <= 5'h00;
         ph_q <= 4'h0;
      end else if (!done) begin
         ph_q <= ph_q + 4'h1;
         if (ph_q == 4'h7) begin
            sck <= 1'b1;
            rx <= {rx[15:0], sdo};
         end
         if (ph_q == 4'hf) begin
            sck <= 1'b0;
            n_q <= n_q + 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
// --------------
// Bench top.
// --------------
module testbench import sadc_pkg::*;;
   logic clk = 1'b0;
   logic rst_n;
   sadc_pins_t p;
   logic [15:0] smp;
   logic bclk_o, bclk_oe, sdo, poe, busy, psave, refon, hsck, hgo, hdone, pb;
   logic [7:0] pout;
   logic [16:0] hrx;
   logic [15:0] isr = 16'h0000;
   wire logic bclk;
   int ipul = 0;
   int k;
   int err_total = 0;
   int compares = 0;
   assign bclk = bclk_oe ? bclk_o : hsck;
   always #5 clk = ~clk;
   sadc_top #(.CONV_CYCLES(20), .QUARTER_CYCLES(5)) u_dut (
      .clk, .rst_n, .cs_n(p.cs_n), .rd_conv(p.rd_conv), .byte_sel(p.byte_sel),
      .output_code_select(p.output_code_select), .serial_clock_source_select(p.serial_clock_source_select),
      .tag_in(p.tag_in), .power_down_in(p.power_down_in), .reference_disable(p.reference_disable),
      .sample_in(smp), .serial_bit_clock_i(bclk), .serial_bit_clock_o(bclk_o),
      .serial_bit_clock_oe(bclk_oe), .serial_data_out(sdo), .parallel_out(pout), .parallel_oe(poe),
      .busy, .power_save(psave), .internal_ref_on(refon));
   sadc_host_model u_host (.clk, .go(hgo), .sdo, .sck(hsck), .rx(hrx), .done(hdone));
   always @(posedge clk) begin
      pb <= bclk_o;
      if (bclk_o && !pb) begin
         isr <= {isr[14:0], sdo};
         ipul <= ipul + 1;
      end
   end
   task automatic report_and_stop();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [16:0] s, input logic [16:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wt(ref logic s, input logic v);
      for (int i = 0; i < 1000 && s !== v; i++) @(posedge clk);
      if (s !== v) begin
         err_total++;
         report_and_stop();
      end
   endtask
   task automatic conv(input logic [15:0] s, input int m);
      @(posedge clk);
      smp <= s;
      p.rd_conv <= 1'b0;
      if (m == 2) repeat (4) @(posedge clk);
      p.cs_n <= 1'b0;
      wt(busy, 1'b0);
      if (m == 1) begin
         repeat (3) @(posedge clk) p.rd_conv <= 1'b1;
         repeat (3) @(posedge clk) p.rd_conv <= 1'b0;
      end
      @(posedge clk) p.rd_conv <= 1'b1;
      wt(busy, 1'b1);
   endtask
   task automatic rdp(input logic b, input logic [7:0] e);
      @(posedge clk) p.byte_sel <= b;
      repeat (5) @(posedge clk);
      chk(pout, e);
      chk(poe, 1'b1);
   endtask
   initial begin
      p = '0;
      p.cs_n = 1'b1;
      p.rd_conv = 1'b1;
      p.output_code_select = 1'b1;
      p.tag_in = 1'b1;
      smp = 16'h0000;
      hgo = 1'b0;
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(busy, 1'b1);
      chk(poe, 1'b0);
      p.cs_n <= 1'b0;
      rdp(1'b0, 8'h00);
      k = ipul;
      conv(16'h8a5c, 0);
      chk(isr, 16'h0000);
      chk(ipul - k, 16);
      chk(bclk_o, 1'b0);
      chk(sdo, 1'b1);
      rdp(1'b0, 8'h8a);
      rdp(1'b1, 8'h5c);
      p.tag_in <= 1'b0;
      k = ipul;
      conv(16'h1234, 1);
      chk(isr, 16'h8a5c);
      chk(ipul - k, 16);
      chk(sdo, 1'b0);
      repeat (10) @(posedge clk);
      chk(busy, 1'b1);
      p.output_code_select <= 1'b0;
      conv(16'h1234, 0);
      chk(isr, 16'h9234);
      rdp(1'b0, 8'h92);
      p.power_down_in <= 1'b1;
      p.reference_disable <= 1'b1;
      repeat (5) @(posedge clk);
      chk(psave, 1'b1);
      chk(refon, 1'b0);
      p.rd_conv <= 1'b0;
      repeat (12) @(posedge clk);
      chk(poe, 1'b0);
      chk(busy, 1'b1);
      p.rd_conv <= 1'b1;
      @(posedge clk) p.power_down_in <= 1'b0;
      p.reference_disable <= 1'b0;
      rdp(1'b1, 8'h34);
      chk(refon, 1'b1);
      p.serial_clock_source_select <= 1'b1;
      p.tag_in <= 1'b1;
      p.cs_n <= 1'b1;
      repeat (5) @(posedge clk);
      conv(16'hc3a1, 2);
      hgo <= 1'b1;
      wt(hdone, 1'b1);
      chk(hrx, {16'h43a1, 1'b1});
      report_and_stop();
   end
endmodule
`default_nettype wire
